// ==== gtl_ctl_model.sv ====
// Bus controller model: sends commands or data, accepts talked bytes.
`timescale 1ns/1ps
module gtl_ctl_model (
	input  wire       ref_clk,
	input  wire [7:0] dio_oe,
	input  wire       dav_oe, nrfd_oe, ndac_oe, eoi_oe,
	output reg  [7:0] c_dio,
	output reg        c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ifc
);
	integer   n;
	integer   n_to = 0;
	reg [7:0] got;
	reg       got_e;
	// A wait that runs out is counted in n_to, so a stuck port fails the run.
	initial {c_dio, c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ifc} = 14'h0008;
	// Released lines fall back to the pull-up, which reads as not asserted.
	task send(input [7:0] d, input a, input e);
		begin
			@(posedge ref_clk);
			{c_dio, c_atn, c_eoi, c_ndac} <= {d, a, e, 1'b0};
			for (n = 0; n < 99 && nrfd_oe; n++) @(posedge ref_clk);
			if (nrfd_oe) n_to = n_to + 1;
			repeat (3) @(posedge ref_clk);
			c_dav <= 1;
			repeat (4) @(posedge ref_clk);
			for (n = 0; n < 99 && ndac_oe; n++) @(posedge ref_clk);
			if (ndac_oe) n_to = n_to + 1;
			got <= dio_oe;
			{c_dav, c_dio, c_eoi, c_ndac} <= 11'h001;
		end
	endtask
	task recv(input integer slow);
		begin
			for (n = 0; n < 199 && !dav_oe; n++) @(posedge ref_clk);
			if (!dav_oe) n_to = n_to + 1;
			got <= dio_oe;
			got_e <= eoi_oe;
			c_nrfd <= 1;
			repeat (slow) @(posedge ref_clk);
			c_ndac <= 0;
			for (n = 0; n < 99 && dav_oe; n++) @(posedge ref_clk);
			if (dav_oe) n_to = n_to + 1;
			{c_ndac, c_nrfd} <= 2'b10;
		end
	endtask
endmodule

// ==== gtl_port.v ====
// Device-side IEEE 488 talker/listener port with source and acceptor handshakes.
// Behaviour
// - Basic talker, serial poll, unaddressed on own listen.
// - Basic listener, unaddressed on any other listen address.
// - Never answer a parallel poll.
// - Group execute trigger is ignored.
// - Lines only pulled low, otherwise released.
// - Talker addressing uses primary address only.
// - Listener addressing uses primary address only.
`timescale 1ns/1ps
`include "gtl_regs.vh"
module gtl_port (
	// Clock and reset.
	input  wire       ref_clk,
	input  wire       srst,
	// Configuration.
	input  wire [4:0] bus_addr,
	// Bus inputs, true when the line is asserted (low on the wire).
	input  wire [7:0] dio_in,
	input  wire       dav_in,
	input  wire       nrfd_in,
	input  wire       ndac_in,
	input  wire       eoi_in,
	input  wire       atn_in,
	input  wire       ifc_in,
	// Bus drives, enable high pulls the line low.
	output reg  [7:0] dio_oe,
	output reg        dav_oe,
	output reg        nrfd_oe,
	output reg        ndac_oe,
	output reg        eoi_oe,
	output reg        srq_oe,
	// Received data to the instrument.
	output reg  [7:0] rx_data,
	output reg        rx_end,
	output reg        rx_valid,
	input  wire       rx_ready,
	// Data to send from the instrument.
	input  wire [7:0] tx_data,
	input  wire       tx_end,
	input  wire       tx_valid,
	output reg        tx_ready,
	// Service request and status.
	input  wire       rsv_set,
	input  wire [7:0] status_byte,
	output reg        dev_clear,
	output reg        talk_state,
	output reg        listen_state
);
	localparam S_IDLE   = 2'h0;
	localparam S_SETTLE = 2'h1;
	localparam S_DAV    = 2'h2;
	localparam S_WAIT   = 2'h3;

	wire [7:0] dio;
	wire [5:0] ctl;
	wire       dav;
	wire       nrfd;
	wire       ndac;
	wire       eoi;
	wire       atn;
	wire       ifc;

	reg        spe;
	reg        spas;
	reg        rsv;
	reg        acc_busy;
	reg  [1:0] sh_state;
	reg  [6:0] sh_cnt;
	reg  [7:0] sh_byte;
	reg        sh_end;
	reg        sh_serial;
	reg        next_rsv;

	gtl_sync2 #(.W(8)) u_sd (
		.ref_clk (ref_clk),
		.srst    (srst),
		.d       (dio_in),
		.q       (dio)
	);
	gtl_sync2 #(.W(6)) u_sc (
		.ref_clk (ref_clk),
		.srst    (srst),
		.d       ({dav_in, nrfd_in, ndac_in, eoi_in, atn_in, ifc_in}),
		.q       (ctl)
	);
	assign dav  = ctl[5];
	assign nrfd = ctl[4];
	assign ndac = ctl[3];
	assign eoi  = ctl[2];
	assign atn  = ctl[1];
	assign ifc  = ctl[0];

	// Primary address match only; secondary addresses are never decoded.
	function is_addr;
		input [6:0] b;
		input [1:0] grp;
		input [4:0] a;
		begin
			is_addr = (b[6:5] == grp) && (b[4:0] == a) && (b[4:0] != 5'h1f);
		end
	endfunction

	wire addr_cmd = atn && dav && !acc_busy;
	wire [6:0] cmd = dio[6:0];
	wire my_listen = addr_cmd && is_addr(cmd, `GTL_LAG_BASE, bus_addr);
	wire any_listen = addr_cmd && (cmd[6:5] == `GTL_LAG_BASE);
	wire my_talk = addr_cmd && is_addr(cmd, `GTL_TAG_BASE, bus_addr);
	wire other_talk = addr_cmd && (cmd[6:5] == `GTL_TAG_BASE) && !my_talk;
	wire data_byte = !atn && dav && !acc_busy && listen_state;

	// Service request: held until the controller polls the status byte out.
	always @* begin
		next_rsv = rsv;
		if (sh_state == S_WAIT && sh_serial && !ndac)
			next_rsv = 1'b0;
		if (rsv_set)
			next_rsv = 1'b1;
	end

	always @(posedge ref_clk) begin
		if (srst || ifc) begin
			talk_state   <= 1'b0;
			listen_state <= 1'b0;
			spe          <= 1'b0;
			spas         <= 1'b0;
			rsv          <= 1'b0;
			acc_busy     <= 1'b0;
			dev_clear    <= 1'b0;
			rx_data      <= 8'h00;
			rx_end       <= 1'b0;
			rx_valid     <= 1'b0;
			nrfd_oe      <= 1'b0;
			ndac_oe      <= 1'b0;
			srq_oe       <= 1'b0;
		end else begin
			rsv       <= next_rsv;
			dev_clear <= 1'b0;
			srq_oe    <= next_rsv && !spas;
			if (rx_valid && rx_ready)
				rx_valid <= 1'b0;
			// Acceptor: all devices join the handshake while attention is asserted.
			if (!dav) begin
				acc_busy <= 1'b0;
				ndac_oe  <= (atn || listen_state) ? 1'b1 : 1'b0;
				nrfd_oe  <= (listen_state && !atn && rx_valid) ? 1'b1 : 1'b0;
			end else if (!acc_busy && (atn || listen_state)) begin
				acc_busy <= 1'b1;
				nrfd_oe  <= 1'b1;
				ndac_oe  <= 1'b0;
			end
			if (my_listen) begin
				listen_state <= 1'b1;
				talk_state   <= 1'b0;
			end else if (any_listen) begin
				// Any other listen address, unlisten included, ends listening.
				listen_state <= 1'b0;
			end
			if (my_talk) begin
				talk_state <= 1'b1;
			end else if (other_talk) begin
				talk_state <= 1'b0;
			end
			if (addr_cmd && cmd == `GTL_CMD_SPE)
				spe <= 1'b1;
			if (addr_cmd && cmd == `GTL_CMD_SPD)
				spe <= 1'b0;
			if (addr_cmd && (cmd == `GTL_CMD_DCL || (cmd == `GTL_CMD_SDC && listen_state)))
				dev_clear <= 1'b1;
			// A group execute trigger or a parallel poll command falls through
			// with no action, so the data lines are never driven for a parallel poll.
			if (data_byte) begin
				rx_data  <= dio;
				rx_end   <= eoi;
				rx_valid <= 1'b1;
			end
			if (!atn && talk_state && spe)
				spas <= 1'b1;
			else if (atn)
				spas <= 1'b0;
		end
	end

	// Source handshake: data settle, then assert valid until all accept.
	always @(posedge ref_clk) begin
		if (srst || ifc || atn) begin
			sh_state  <= S_IDLE;
			sh_cnt    <= 7'h00;
			sh_byte   <= 8'h00;
			sh_end    <= 1'b0;
			sh_serial <= 1'b0;
			dio_oe    <= 8'h00;
			dav_oe    <= 1'b0;
			eoi_oe    <= 1'b0;
			tx_ready  <= 1'b0;
		end else begin
			tx_ready <= 1'b0;
			case (sh_state)
				S_IDLE: begin
					if (talk_state && spe) begin
						sh_byte   <= {status_byte[7], rsv, status_byte[5:0]};
						sh_end    <= 1'b0;
						sh_serial <= 1'b1;
						sh_cnt    <= 7'h00;
						sh_state  <= S_SETTLE;
					end else if (talk_state && tx_valid && !tx_ready) begin
						sh_byte   <= tx_data;
						sh_end    <= tx_end;
						sh_serial <= 1'b0;
						tx_ready  <= 1'b1;
						sh_cnt    <= 7'h00;
						sh_state  <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					dio_oe <= sh_byte;
					eoi_oe <= sh_end;
					// Saturate so a long not-ready stall cannot wrap the settle count.
					if (sh_cnt != 7'h7f)
						sh_cnt <= sh_cnt + 7'h01;
					if ({25'h0, sh_cnt} >= (`GTL_SETTLE_CYC - 1) && !nrfd && ndac)
						sh_state <= S_DAV;
				end
				S_DAV: begin
					dav_oe   <= 1'b1;
					sh_state <= S_WAIT;
				end
				S_WAIT: begin
					if (!ndac) begin
						dav_oe   <= 1'b0;
						dio_oe   <= 8'h00;
						eoi_oe   <= 1'b0;
						sh_state <= sh_serial ? S_WAIT : S_IDLE;
					end
				end
				default: sh_state <= S_IDLE;
			endcase
		end
	end
endmodule

// ==== gtl_port_assertions.sv ====
// Checker on the ports of the talker/listener port.
`timescale 1ns/1ps
module gtl_port_chk (
	input wire       ref_clk, srst, ndac_in, eoi_in, atn_in, ifc_in, rx_ready,
	input wire       dav_oe, nrfd_oe, rx_valid, dev_clear, talk_state, listen_state,
	input wire [7:0] dio_oe, rx_data
);
	// An interface clear resets the port, so hold checks wait until it is well past.
	reg  [2:0] ifc_h;
	wire       calm = !ifc_in && ifc_h == 3'h0;
	always @(posedge ref_clk) ifc_h <= {ifc_h[1:0], ifc_in};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_no_ppoll: assert property ((atn_in && eoi_in)[*4] |-> dio_oe == 8'h00)
		else $error("poll drive");
	a_dav_talker: assert property ($rose(dav_oe) |-> talk_state)
		else $error("dav not talker");
	a_dav_settle: assert property ($rose(dav_oe) |-> dio_oe == $past(dio_oe, 39))
		else $error("dav early");
	a_dav_hold: assert property ((dav_oe && ndac_in && !atn_in && calm)[*6] |=> dav_oe)
		else $error("dav dropped");
	a_rx_stall: assert property (rx_valid && $past(rx_valid) |-> nrfd_oe)
		else $error("no stall");
	a_rx_hold: assert property (rx_valid && !rx_ready && calm |=> rx_valid && $stable(rx_data))
		else $error("rx lost");
	a_ifc_idle: assert property (ifc_in[*4] |-> !talk_state && !listen_state && !dav_oe)
		else $error("ifc ignored");
	a_clr_pulse: assert property (dev_clear |=> !dev_clear)
		else $error("clear long");
	c_talk: cover property ($rose(dav_oe));
	c_stall: cover property (rx_valid && !rx_ready);
	c_clear: cover property (dev_clear);
endmodule
bind gtl_port gtl_port_chk chk (.*);

// ==== gtl_regs.vh ====
// Constants for the IEEE 488 talker/listener port.
`ifndef GTL_REGS_VH
`define GTL_REGS_VH
`define GTL_CMD_LLO      7'h11
`define GTL_CMD_DCL      7'h14
`define GTL_CMD_PPU      7'h15
`define GTL_CMD_SPE      7'h18
`define GTL_CMD_SPD      7'h19
`define GTL_CMD_GET      7'h08
`define GTL_CMD_SDC      7'h04
`define GTL_CMD_UNL      7'h3f
`define GTL_CMD_UNT      7'h5f
`define GTL_LAG_BASE     2'h1
`define GTL_TAG_BASE     2'h2
`define GTL_SRQ_BIT      6
`define GTL_SETTLE_NS    2000
`define GTL_CLK_NS       50
`define GTL_SETTLE_CYC   ((`GTL_SETTLE_NS + `GTL_CLK_NS - 1) / `GTL_CLK_NS)
`endif

// ==== gtl_sync2.v ====
// Two-stage level register for the bus data and control lines.
`timescale 1ns/1ps
module gtl_sync2 #(
	parameter W = 8
) (
	// Clock and reset.
	input  wire         ref_clk,
	input  wire         srst,
	// Level in and settled level out.
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] stage;
	always @(posedge ref_clk) begin
		if (srst) begin
			stage <= {W{1'b0}};
			q     <= {W{1'b0}};
		end else begin
			stage <= d;
			q     <= stage;
		end
	end
endmodule

// ==== tb.sv ====
// Testbench: listening, talking, clear, poll and interface clear.
`timescale 1ns/1ps
module tb;
	reg        ref_clk, srst, rx_ready, tx_end, tx_valid, rsv_set;
	reg  [4:0] bus_addr;
	reg  [7:0] tx_data, status_byte, d;
	wire [7:0] dio_oe, rx_data, c_dio;
	wire       dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, rx_end, rx_valid, tx_ready, dev_clear;
	wire       talk_state, listen_state, c_dav, c_nrfd, c_ndac, c_atn, c_eoi, c_ifc;
	wire [7:0] dio_in = dio_oe | c_dio;
	wire       dav_in = dav_oe | c_dav, nrfd_in = nrfd_oe | c_nrfd, ndac_in = ndac_oe | c_ndac;
	wire       eoi_in = eoi_oe | c_eoi, atn_in = c_atn, ifc_in = c_ifc;
	integer    n_mismatch = 0, checks = 0, nclr = 0, i, k;
	gtl_port DUT (.*);
	gtl_ctl_model m (.*);
	initial begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (dev_clear) nclr <= nclr + 1;
	function [7:0] poll(input [7:0] s); poll = {s[7], 1'b1, s[5:0]}; endfunction
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			$display("mismatches %0d checks %0d", n_mismatch, checks);
			if (n_mismatch == 0 && checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task cmd(input [7:0] c);
		begin
			m.send(c, 1, 0);
			repeat (4) @(posedge ref_clk);
		end
	endtask
	task talk_one(input integer slow);
		begin
			d = $urandom;
			@(posedge ref_clk);
			{tx_data, tx_end, tx_valid} <= {d, slow[0], 1'b1};
			fork
				m.recv(slow);
				begin
					for (i = 0; i < 99 && !tx_ready; i++) @(posedge ref_clk);
					chk(tx_ready, 1'b1);
					tx_valid <= 0;
				end
			join
			chk(m.got, d);
			chk(m.got_e, slow[0]);
		end
	endtask
	initial begin
		{srst, rx_ready, tx_end, tx_valid, rsv_set} = 5'h10;
		d = $urandom(5010);
		tx_data = 8'h00;
		status_byte = $urandom;
		bus_addr = 5'h1 + $urandom % 29;
		repeat (8) @(posedge ref_clk);
		srst <= 0;
		cmd({3'h1, bus_addr});
		for (k = 0; k < 4; k++) begin
			d = $urandom;
			m.send(d, 0, k == 3);
			repeat (6) @(posedge ref_clk);
			chk(rx_data, d);
			chk({rx_end, rx_valid}, {k == 3, 1'b1});
			rx_ready <= 1;
			@(posedge ref_clk) rx_ready <= 0;
		end
		cmd(8'h08);
		chk(listen_state, 1'b1);
		m.send(8'h00, 1, 1);
		chk(m.got, 8'h00);
		cmd(8'h04);
		cmd(8'h14);
		chk(nclr[7:0], 8'h02);
		cmd({3'h1, bus_addr ^ 5'h01});
		chk(listen_state, 1'b0);
		cmd({3'h1, bus_addr});
		chk(listen_state, 1'b1);
		cmd(8'h3f);
		chk(listen_state, 1'b0);
		cmd({3'h2, bus_addr});
		m.c_atn <= 0;
		talk_one(1);
		talk_one(30);
		rsv_set <= 1;
		@(posedge ref_clk) rsv_set <= 0;
		cmd(8'h18);
		chk(srq_oe, 1'b1);
		m.c_atn <= 0;
		m.recv(2);
		chk(m.got, poll(status_byte));
		cmd(8'h19);
		chk(srq_oe, 1'b0);
		cmd({3'h1, bus_addr});
		chk({talk_state, listen_state}, 8'h01);
		cmd({3'h2, bus_addr});
		m.c_ifc <= 1;
		repeat (6) @(posedge ref_clk);
		m.c_ifc <= 0;
		repeat (4) @(posedge ref_clk);
		chk({talk_state, listen_state}, 8'h00);
		chk(m.n_to[7:0], 8'h00);
		close_out;
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		n_mismatch = n_mismatch + 1;
		close_out;
	end
endmodule
